// ==== common/power_stage_pkg.sv ====
// shared constants and types of the power stage gate control
// assumes a 25 MHz core clock; all times are converted to cycles here
package power_stage_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int POR_DELAY_US = 220;
   localparam int POR_DELAY_CYCLES =
      (POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GATE_RECOVER_US = 210;
   localparam int GATE_RECOVER_CYCLES =
      (GATE_RECOVER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_NS = 350;
   localparam int BLANK_CYCLES =
      (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRI_HOLDOFF_NS = 45;
   localparam int TRI_HOLDOFF_CYCLES = (TRI_HOLDOFF_NS / CLK_PERIOD_NS < 1) ?
      1 : TRI_HOLDOFF_NS / CLK_PERIOD_NS;
   localparam int DEAD_NS = 6;
   localparam int DEAD_CYCLES = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LINK_IDLE_NS = 2000;
   localparam int LINK_IDLE_CYCLES = LINK_IDLE_NS / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // counter widths and reset values
   // ----------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int SHORT_W = 4;
   localparam int IDLE_W = 8;
   localparam logic [1:0] PSTATE_RESET = 2'h0;
   localparam logic [7:0] CAL_DEFAULT = 8'h5a;
   // ----------------------------------------------------------------
   // serial link command byte: opcode in the upper nibble
   // ----------------------------------------------------------------
   localparam int CMD_OP_POS = 4;
   localparam logic [3:0] CMD_INIT = 4'h1;
   localparam logic [3:0] CMD_PSTATE = 4'h2;
   localparam logic [3:0] CMD_TEMP_GRANT = 4'h3;
   localparam logic [3:0] CMD_TEMP_REVOKE = 4'h4;
   localparam logic [3:0] CMD_CLEAR_FAULT = 4'h5;
   localparam logic [3:0] CMD_READ_CAL = 4'h6;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {pwm_low_lvl, pwm_high_lvl, pwm_tri_lvl}
      pwm_level_t;
   typedef enum logic [1:0] {current_monitor_out_zero, current_monitor_out_track, current_monitor_out_hold,
      current_monitor_out_fault_high} current_monitor_out_mode_t;
endpackage

// ==== common/link_cmd_if.sv ====
// decoded serial link commands passed from the link slave to the core
// assumes both ends run on the same core clock
interface link_cmd_if;
   logic init_cmd;
   logic clear_fault_cmd;
   logic temp_grant;
   logic [1:0] power_state;
   modport slave (output init_cmd, output clear_fault_cmd,
      output temp_grant, output power_state);
   modport core (input init_cmd, input clear_fault_cmd,
      input temp_grant, input power_state);
endinterface

// ==== verilog/pwm_level_decoder.sv ====
// three-level pwm input decoder with tri-state hold-off counter
// assumes two comparator pins, asynchronous to clk
module pwm_level_decoder
   import power_stage_pkg::*;
#(
   parameter int HOLDOFF = TRI_HOLDOFF_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic pwm_above_high,
   input wire logic pwm_below_low,
   output pwm_level_t pwm_level,
   output logic tri_off
);
   if (HOLDOFF < 1 || HOLDOFF >= (1 << SHORT_W)) begin : g_chk
      $error("tri-state hold-off out of range");
   end

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      pwm_level_t lvl;
      logic [SHORT_W-1:0] cnt;
      logic off;
   } dec_t;

   dec_t r, nxt;

   always_comb begin
      nxt = r;
      nxt.s1 = {pwm_above_high, pwm_below_low};
      nxt.s2 = r.s1;
      if (r.s2[1]) begin
         nxt.lvl = pwm_high_lvl;
      end else if (r.s2[0]) begin
         nxt.lvl = pwm_low_lvl;
      end else begin
         nxt.lvl = pwm_tri_lvl;
      end
      if (nxt.lvl != pwm_tri_lvl) begin
         // leaving tri-state releases at once
         nxt.cnt = '0;
         nxt.off = 1'b0;
      end else if (r.cnt == SHORT_W'(HOLDOFF - 1)) begin
         nxt.off = 1'b1;
      end else begin
         nxt.cnt = r.cnt + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{s1: 2'h0, s2: 2'h0, lvl: pwm_tri_lvl, cnt: '0, off: 1'b0};
      end else begin
         r <= nxt;
      end
   end

   assign pwm_level = r.lvl;
   assign tri_off = r.off;

   a_tri_release: assert property (
      @(posedge clk) disable iff (!resetn)
      (pwm_level != pwm_tri_lvl) |-> !tri_off)
      else $error("tri-state shutdown held outside tri-state");
endmodule

// ==== verilog/serial_link_slave.sv ====
// serial control link slave: byte commands in, calibration byte out
// assumes the link clock is sampled by clk and idles low between frames
module serial_link_slave
   import power_stage_pkg::*;
#(
   parameter logic [7:0] CAL_DATA = CAL_DEFAULT,
   parameter int IDLE = LINK_IDLE_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic serial_link_clock,
   input wire logic serial_link_data_in,
   output logic serial_link_data_out,
   output logic serial_link_data_oe,
   link_cmd_if.slave cmd
);
   if (IDLE < 2 || IDLE >= (1 << IDLE_W)) begin : g_chk
      $error("link idle count out of range");
   end

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic clk_prev;
      logic [7:0] shift;
      logic [2:0] bits;
      logic [IDLE_W-1:0] idle;
      logic reading;
      logic [7:0] cal;
      logic oe;
      logic init;
      logic clear;
      logic grant;
      logic [1:0] pstate;
   } link_t;

   link_t r, nxt;
   logic rise, fall;
   logic [7:0] byte_in;

   always_comb begin
      nxt = r;
      nxt.s1 = {serial_link_clock, serial_link_data_in};
      nxt.s2 = r.s1;
      nxt.clk_prev = r.s2[1];
      nxt.init = 1'b0;
      nxt.clear = 1'b0;
      // edges found by oversampling; 2 MHz still gives 6 samples high
      rise = r.s2[1] & ~r.clk_prev;
      fall = ~r.s2[1] & r.clk_prev;
      byte_in = {r.shift[6:0], r.s2[0]};
      if (r.s2[1]) begin
         nxt.idle = '0;
      end else if (r.idle == IDLE_W'(IDLE)) begin
         // clock parked low: resynchronise framing
         nxt.bits = '0;
         nxt.reading = 1'b0;
         nxt.oe = 1'b0;
      end else begin
         nxt.idle = r.idle + 8'h01;
      end
      if (rise) begin
         nxt.bits = r.bits + 3'h1;
         if (r.reading) begin
            if (r.bits == 3'h7) begin
               nxt.reading = 1'b0;
            end
         end else begin
            nxt.shift = byte_in;
            if (r.bits == 3'h7) begin
               case (byte_in[7:CMD_OP_POS])
                  CMD_INIT: nxt.init = 1'b1;
                  CMD_PSTATE: nxt.pstate = byte_in[1:0];
                  CMD_TEMP_GRANT: nxt.grant = 1'b1;
                  CMD_TEMP_REVOKE: nxt.grant = 1'b0;
                  CMD_CLEAR_FAULT: nxt.clear = 1'b1;
                  CMD_READ_CAL: begin
                     nxt.reading = 1'b1;
                     nxt.cal = CAL_DATA;
                  end
                  default: nxt.shift = byte_in;
               endcase
            end
         end
      end
      if (fall) begin
         // only ever pull low; a one is left to the pull-up
         nxt.oe = r.reading & ~r.cal[7];
         nxt.cal = {r.cal[6:0], 1'b0};
      end
      if (!r.reading && !nxt.reading) begin
         nxt.oe = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{s1: 2'h0, s2: 2'h0, clk_prev: 1'b0, shift: 8'h00,
            bits: 3'h0, idle: '0, reading: 1'b0, cal: 8'h00, oe: 1'b0,
            init: 1'b0, clear: 1'b0, grant: 1'b0, pstate: PSTATE_RESET};
      end else begin
         r <= nxt;
      end
   end

   assign serial_link_data_out = 1'b0;
   assign serial_link_data_oe = r.oe;
   assign cmd.init_cmd = r.init;
   assign cmd.clear_fault_cmd = r.clear;
   assign cmd.temp_grant = r.grant;
   assign cmd.power_state = r.pstate;
endmodule

// ==== verilog/power_stage_gate_control.sv ====
// power stage gate control: start-up, gate gating, current and fault
// monitor, serial link command handling
// assumes supply, temperature and pwm comparators as asynchronous pins
module power_stage_gate_control
   import power_stage_pkg::*;
#(
   parameter int POR_DELAY = POR_DELAY_CYCLES,
   parameter int GATE_RECOVER = GATE_RECOVER_CYCLES,
   parameter logic [7:0] CAL_DATA = CAL_DEFAULT
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic logic_supply_good,
   input wire logic logic_supply_brownout,
   input wire logic gate_supply_good,
   input wire logic pwm_above_high,
   input wire logic pwm_below_low,
   input wire logic temp_above_trip,
   input wire logic temp_below_release,
   input wire logic serial_link_clock,
   input wire logic serial_link_data_in,
   output logic serial_link_data_out,
   output logic serial_link_data_oe,
   output logic high_side_gate_drive,
   output logic low_side_gate_drive,
   output current_monitor_out_mode_t current_monitor_mode,
   output logic current_sample_strobe,
   output logic temperature_monitor_enable,
   output logic [1:0] power_state,
   output logic fault_latched
);
   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (POR_DELAY < 1 || POR_DELAY >= (1 << CNT_W)) begin : g_chk_por
      $error("start-up delay out of range");
   end
   if (GATE_RECOVER < 1 || GATE_RECOVER >= (1 << CNT_W)) begin : g_chk_rec
      $error("gate recovery delay out of range");
   end
   if (BLANK_CYCLES >= (1 << SHORT_W) ||
      DEAD_CYCLES >= (1 << SHORT_W)) begin : g_chk_short
      $error("blanking or dead time too long");
   end

   // ----------------------------------------------------------------
   // sub-blocks
   // ----------------------------------------------------------------
   link_cmd_if link ();
   pwm_level_t pwm_level;
   logic tri_off;

   serial_link_slave #(
      .CAL_DATA(CAL_DATA),
      .IDLE(LINK_IDLE_CYCLES)
   ) u_link (
      .clk(clk),
      .resetn(resetn),
      .serial_link_clock(serial_link_clock),
      .serial_link_data_in(serial_link_data_in),
      .serial_link_data_out(serial_link_data_out),
      .serial_link_data_oe(serial_link_data_oe),
      .cmd(link)
   );

   pwm_level_decoder #(
      .HOLDOFF(TRI_HOLDOFF_CYCLES)
   ) u_pwm (
      .clk(clk),
      .resetn(resetn),
      .pwm_above_high(pwm_above_high),
      .pwm_below_low(pwm_below_low),
      .pwm_level(pwm_level),
      .tri_off(tri_off)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {st_lockout, st_wait_init, st_por_delay,
      st_run, st_gate_lockout, st_fault} stage_t;

   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      stage_t st;
      logic [CNT_W-1:0] cnt;
      logic [SHORT_W-1:0] blank;
      logic [SHORT_W-1:0] dead;
      logic hs;
      logic ls;
      logic first_gl;
      logic ot;
      logic fault;
      logic brown;
      logic pwm_hi_prev;
      current_monitor_out_mode_t mode;
      logic strobe;
      logic temp_en;
   } core_t;

   core_t r, nxt;
   logic lsg, gsg, bro, tab, tbr;
   logic allow, want_hs, want_ls, fault_set;

   function automatic logic supplies_ok(input logic lg, input logic gg,
      input logic br);
      supplies_ok = lg & gg & ~br;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt = r;
      nxt.s1 = {logic_supply_good, gate_supply_good, logic_supply_brownout,
         temp_above_trip, temp_below_release};
      nxt.s2 = r.s1;
      {lsg, gsg, bro, tab, tbr} = r.s2;
      allow = 1'b0;
      // a logic supply loss or brownout in run or gate lockout latches; set beats a same-cycle clear
      fault_set = (r.st == st_run || r.st == st_gate_lockout) &&
         (!lsg || bro);
      nxt.fault = fault_set | (r.fault & ~link.clear_fault_cmd);
      if (fault_set) begin
         nxt.brown = bro;
      end
      case (r.st)
         st_lockout: begin
            if (lsg && gsg) begin
               nxt.st = st_wait_init;
            end
         end
         st_wait_init: begin
            if (!(lsg && gsg)) begin
               nxt.st = st_lockout;
            end else if (link.init_cmd) begin
               nxt.st = st_por_delay;
               nxt.cnt = '0;
            end
         end
         st_por_delay: begin
            nxt.cnt = r.cnt + 16'h0001;
            if (!(lsg && gsg)) begin
               nxt.st = st_lockout;
            end else if (r.cnt == CNT_W'(POR_DELAY - 1)) begin
               nxt.st = st_run;
               nxt.first_gl = 1'b0;
            end
         end
         st_run: begin
            allow = supplies_ok(lsg, gsg, bro);
            if (fault_set) begin
               nxt.st = st_fault;
            end else if (!gsg) begin
               nxt.st = st_gate_lockout;
               nxt.cnt = '0;
            end
         end
         st_gate_lockout: begin
            nxt.cnt = r.cnt + 16'h0001;
            if (fault_set) begin
               nxt.st = st_fault;
            end else if (!gsg) begin
               nxt.cnt = '0;
            end else if (r.cnt == CNT_W'(GATE_RECOVER - 1)) begin
               nxt.st = st_run;
               nxt.first_gl = 1'b0;
            end
         end
         st_fault: begin
            // waits for the link clear; no automatic restart
            if (!r.fault && supplies_ok(lsg, gsg, bro)) begin
               nxt.st = st_run;
               nxt.first_gl = 1'b0;
               nxt.brown = 1'b0;
            end
         end
         default: nxt.st = st_lockout;
      endcase

      // gate command; during tri-state before hold-off keep present drive
      if (pwm_level == pwm_tri_lvl && !tri_off) begin
         want_hs = allow & r.hs;
         want_ls = allow & r.ls;
      end else begin
         want_hs = allow & (pwm_level == pwm_high_lvl) & ~tri_off;
         want_ls = allow & (pwm_level == pwm_low_lvl) & ~tri_off;
      end
      if (r.dead != '0) begin
         nxt.dead = r.dead - 4'h1;
      end
      if ((r.hs && !want_hs) || (r.ls && !want_ls)) begin
         // turn-off first, then a dead gap before any turn-on
         nxt.hs = 1'b0;
         nxt.ls = 1'b0;
         nxt.dead = SHORT_W'(DEAD_CYCLES);
      end else if (!r.hs && !r.ls && r.dead == '0) begin
         nxt.hs = want_hs;
         nxt.ls = want_ls;
      end
      if (r.ls && r.st == st_run) begin
         nxt.first_gl = 1'b1;
      end

      // blanking after each falling pwm edge
      nxt.pwm_hi_prev = (pwm_level == pwm_high_lvl);
      nxt.strobe = 1'b0;
      if (r.pwm_hi_prev && pwm_level != pwm_high_lvl) begin
         nxt.blank = SHORT_W'(BLANK_CYCLES);
      end else if (r.blank != '0) begin
         nxt.blank = r.blank - 4'h1;
         nxt.strobe = (r.blank == 4'h1) && (pwm_level == pwm_low_lvl);
      end

      // over-temperature with hysteresis; trip wins over release
      if (tab) begin
         nxt.ot = 1'b1;
      end else if (tbr) begin
         nxt.ot = 1'b0;
      end

      // current monitor mode, highest priority first
      if (r.st == st_fault) begin
         nxt.mode = r.brown ? current_monitor_out_fault_high : current_monitor_out_zero;
      end else if (bro && r.st != st_lockout) begin
         nxt.mode = current_monitor_out_fault_high;
      end else if (!lsg) begin
         nxt.mode = current_monitor_out_zero;
      end else if (r.st == st_gate_lockout || (r.st == st_run && !gsg)) begin
         nxt.mode = current_monitor_out_fault_high;
      end else if (r.ot) begin
         nxt.mode = current_monitor_out_fault_high;
      end else if (r.st != st_run || !r.first_gl) begin
         nxt.mode = current_monitor_out_zero;
      end else if (pwm_level == pwm_low_lvl && r.blank == '0 && r.ls) begin
         nxt.mode = current_monitor_out_track;
      end else begin
         nxt.mode = current_monitor_out_hold;
      end

      nxt.temp_en = link.temp_grant && r.st == st_run;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{s1: 5'h00, s2: 5'h00, st: st_lockout, cnt: '0, blank: '0,
            dead: '0, hs: 1'b0, ls: 1'b0, first_gl: 1'b0, ot: 1'b0,
            fault: 1'b0, brown: 1'b0, pwm_hi_prev: 1'b0, mode: current_monitor_out_zero,
            strobe: 1'b0, temp_en: 1'b0};
      end else begin
         r <= nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign high_side_gate_drive = r.hs;
   assign low_side_gate_drive = r.ls;
   assign current_monitor_mode = r.mode;
   assign current_sample_strobe = r.strobe;
   assign temperature_monitor_enable = r.temp_en;
   assign power_state = link.power_state;
   assign fault_latched = r.fault;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_no_overlap: assert property (!(r.hs && r.ls))
      else $error("both gate drives on");
   a_lockout_gates: assert property (
      (r.st == st_lockout) |=> (!r.hs && !r.ls))
      else $error("gate driven during lockout");
   a_por_delay: assert property (
      (r.st == st_run && $past(r.st) == st_por_delay) |->
      $past(r.cnt) == CNT_W'(POR_DELAY - 1))
      else $error("run entered before start-up delay");
   a_fault_latch: assert property (
      (r.st == st_run && (!lsg || bro)) |=> (r.fault && r.st == st_fault))
      else $error("supply fault not latched");
   a_ot_fault: assert property (
      (r.ot && r.st == st_run && supplies_ok(lsg, gsg, bro)) |=>
      r.mode == current_monitor_out_fault_high)
      else $error("over-temperature not shown on monitor");
   a_ot_hold: assert property ((r.ot && !tbr) |=> r.ot)
      else $error("over-temperature released early");
   a_zero_first: assert property (
      (r.st == st_run && !r.first_gl && !r.ot &&
      supplies_ok(lsg, gsg, bro)) |=> r.mode == current_monitor_out_zero)
      else $error("monitor valid before first low-side pulse");
   a_blank_wait: assert property (
      (r.pwm_hi_prev && pwm_level != pwm_high_lvl) |=> !r.strobe [*8])
      else $error("current sampled inside blanking");
   a_tri_off: assert property (
      (tri_off && pwm_level == pwm_tri_lvl) |=> (!r.hs && !r.ls))
      else $error("tri-state did not turn gates off");
   a_temp_grant: assert property (
      r.temp_en |-> $past(link.temp_grant))
      else $error("temperature driven without grant");
endmodule

// ==== dv/link_master.sv ====
// controller side model of the serial link: clock and open-drain data
// assumes the bench resolves the data wire with a single pull-up
module link_master (
   output logic serial_link_clock,
   output logic pull_low,
   input wire logic data_wire
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      serial_link_clock = 1'b0; // push-pull, low between frames
      pull_low = 1'b0;
   end
   // ------------------------------------------------
   // byte transfers, msb first, 320 ns clock periods
   // ------------------------------------------------
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         pull_low = ~b[i]; // only ever pulls low, pull-up gives ones
         #80 serial_link_clock = 1'b1; // one fixed rate
         #160 serial_link_clock = 1'b0;
         #80;
      end
      pull_low = 1'b0;
   endtask
   task automatic read_byte(output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         #160 serial_link_clock = 1'b1;
         b[i] = data_wire; // sampled on the rising edge
         #160 serial_link_clock = 1'b0;
      end
   endtask
endmodule

// ==== dv/power_stage_gate_control_tb.sv ====
// self-checking bench of the power stage gate control
// assumes the link model and start-up delays cut to DLY cycles
module power_stage_gate_control_tb;
   import power_stage_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DLY = 20;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic lgood = 1'b0, brown = 1'b0, ggood = 1'b0, hot = 1'b0;
   logic cool = 1'b1, pa = 1'b0, pb = 1'b1;
   logic sclk, pull, doe, dout, hs, ls, strobe, temperature_monitor_out_en, fault;
   logic [1:0] pstate;
   logic [7:0] b;
   current_monitor_out_mode_t mode;
   wire data_wire = ~(pull | (doe & ~dout));
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   always #20 clk = ~clk;
   power_stage_gate_control #(.POR_DELAY(DLY), .GATE_RECOVER(DLY))
   u_power_stage_gate_control (.clk(clk), .resetn(resetn),
      .logic_supply_good(lgood), .logic_supply_brownout(brown),
      .gate_supply_good(ggood), .pwm_above_high(pa), .pwm_below_low(pb),
      .temp_above_trip(hot), .temp_below_release(cool),
      .serial_link_clock(sclk), .serial_link_data_in(data_wire),
      .serial_link_data_out(dout), .serial_link_data_oe(doe),
      .high_side_gate_drive(hs), .low_side_gate_drive(ls),
      .current_monitor_mode(mode), .current_sample_strobe(strobe),
      .temperature_monitor_enable(temperature_monitor_out_en), .power_state(pstate),
      .fault_latched(fault));
   link_master u_link_master (.serial_link_clock(sclk), .pull_low(pull),
      .data_wire(data_wire));
   task automatic chk(input string what, input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ------------------------------------------------
   // helpers; #1 lets the edge's updates land first
   // ------------------------------------------------
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic pwm(input logic [1:0] lvl); // 2 high, 1 low, 0 tri
      @(posedge clk);
      {pa, pb} <= lvl;
   endtask
   task automatic send(input logic [3:0] op, input logic [3:0] arg);
      u_link_master.send_byte({op, arg});
      cyc(3);
   endtask
   always @(negedge clk)
      if (resetn) chk("gate overlap", {7'h0, hs & ls}, 8'h00);
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         error_cnt++;
         end_of_test();
      end
   end
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_startup();
      {lgood, ggood, pa, pb} <= 4'h0;
      pwm(2'h2);
      @(posedge clk);
      {lgood, ggood} <= 2'h3;
      cyc(DLY + 10);
      chk("hs before init", hs, 8'h00);
      send(CMD_INIT, 4'h0);
      cyc(7);
      chk("hs in delay", hs, 8'h00);
      cyc(DLY);
      chk("hs in run", hs, 8'h01);
      chk("mode before ls", mode, current_monitor_out_zero);
      chk("temperature_monitor_out no grant", temperature_monitor_out_en, 8'h00);
      $display("test startup done");
   endtask
   task automatic t_switch();
      pwm(2'h1);
      n = 0;
      while (strobe !== 1'b1 && n < 30) begin
         cyc(1);
         n++;
      end
      chk("blank window", {7'h0, n >= 12 && n <= 14}, 8'h01);
      chk("ls on", ls, 8'h01);
      cyc(1);
      chk("mode low", mode, current_monitor_out_track);
      pwm(2'h2);
      cyc(8);
      chk("hs on", hs, 8'h01);
      chk("mode high", mode, current_monitor_out_hold);
      pwm(2'h0);
      cyc(7);
      chk("tri gates", {6'h0, hs, ls}, 8'h00);
      pwm(2'h2);
      cyc(7);
      chk("tri exit", hs, 8'h01);
      $display("test switch done");
   endtask
   task automatic t_link();
      send(CMD_TEMP_GRANT, 4'h0);
      chk("temperature_monitor_out grant", temperature_monitor_out_en, 8'h01);
      send(CMD_TEMP_REVOKE, 4'h0);
      chk("temperature_monitor_out revoke", temperature_monitor_out_en, 8'h00);
      send(4'h0, 4'h3);
      chk("unknown op", {temperature_monitor_out_en, pstate}, 8'h00);
      for (int p = 3; p >= 0; p--) begin
         send(CMD_PSTATE, p[3:0]);
         chk("power state", pstate, p[7:0]);
      end
      u_link_master.send_byte({CMD_READ_CAL, 4'h0});
      u_link_master.read_byte(b);
      chk("calibration", b, CAL_DEFAULT);
      chk("data value", dout, 8'h00);
      $display("test link done");
   endtask
   task automatic t_faults();
      {hot, cool} <= 2'h2;
      pwm(2'h1);
      cyc(8);
      chk("hot mode", mode, current_monitor_out_fault_high);
      chk("hot ls", ls, 8'h01);
      hot <= 1'b0;
      cyc(6);
      chk("between", mode, current_monitor_out_fault_high);
      cool <= 1'b1;
      cyc(6);
      chk("cooled", {7'h0, mode == current_monitor_out_fault_high}, 8'h00);
      ggood <= 1'b0;
      cyc(6);
      chk("gate lockout", {6'h0, hs, ls}, 8'h00);
      chk("gate mode", mode, current_monitor_out_fault_high);
      ggood <= 1'b1;
      cyc(10);
      chk("recovering", ls, 8'h00);
      cyc(DLY + 4);
      chk("recovered", ls, 8'h01);
      lgood <= 1'b0;
      cyc(6);
      chk("logic fault", {6'h0, fault, ls}, 8'h02);
      chk("logic mode", mode, current_monitor_out_zero);
      lgood <= 1'b1;
      cyc(DLY + 6);
      chk("no clear", {6'h0, fault, ls}, 8'h02);
      send(CMD_CLEAR_FAULT, 4'h0);
      cyc(3);
      chk("cleared", {6'h0, fault, ls}, 8'h01);
      brown <= 1'b1;
      cyc(6);
      chk("brownout", {6'h0, fault, ls}, 8'h02);
      chk("brown mode", mode, current_monitor_out_fault_high);
      brown <= 1'b0;
      send(CMD_CLEAR_FAULT, 4'h0);
      cyc(3);
      chk("brown clear", fault, 8'h00);
      $display("test faults done");
   endtask
   initial begin
      cyc(7);
      chk("reset gates", {6'h0, hs, ls}, 8'h00);
      chk("reset mode", mode, current_monitor_out_zero);
      @(posedge clk);
      resetn <= 1'b1;
      t_startup();
      t_switch();
      t_link();
      t_faults();
      end_of_test();
   end
endmodule
